// ==== sxe_exec.v ====
// Decoder and executor for subtract, swap, exchange and exclusive-OR opcodes
`timescale 1ns/1ps
`include "sxe_consts.vh"

module sxe_exec #(
    parameter DW = 8
) (
    input wire clock,
    input wire rst_n,
    input wire exec_start,
    input wire [7:0] opcode,
    input wire [7:0] byte1,
    input wire [7:0] byte2,
    input wire [DW-1:0] acc_in,
    input wire carry_in,
    input wire auxiliary_carry_flag_in,
    input wire overflow_flag_in,
    input wire [1:0] bank_sel,
    input wire [DW-1:0] mem_rd_data,
    output wire decode_hit,
    output wire busy,
    output wire [1:0] instr_bytes,
    output wire [1:0] instr_cycles,
    output reg mem_rd_req_reg,
    output reg [7:0] mem_rd_addr_reg,
    output reg mem_rd_indirect_reg,
    output reg mem_rd_latch_reg,
    output reg mem_wr_en_reg,
    output reg [7:0] mem_wr_addr_reg,
    output reg mem_wr_indirect_reg,
    output reg [DW-1:0] mem_wr_data_reg,
    output reg acc_wr_en_reg,
    output reg [DW-1:0] acc_wr_data_reg,
    output reg flag_wr_en_reg,
    output reg carry_out_reg,
    output reg auxiliary_carry_flag_out_reg,
    output reg overflow_flag_out_reg,
    output reg done_reg
);

    reg [1:0] state_reg;
    reg [7:0] op_reg;
    reg [7:0] b1_reg;
    reg [7:0] b2_reg;
    reg [DW-1:0] acc_reg;
    reg cy_reg;
    reg ac_reg;
    reg ov_reg;
    reg [7:0] ptr_reg;
    reg [DW-1:0] opnd_reg;

    // Decode of the incoming opcode
    wire [3:0] hi = opcode[7:4];
    wire [3:0] lo = opcode[3:0];
    wire lo_src = (lo >= `SXE_LO_IMM);
    wire is_sub = (hi == `SXE_GRP_SUB) && lo_src;
    wire is_xor = (hi == `SXE_GRP_XOR) && (lo >= `SXE_LO_XOR_DA);
    wire is_swap = (opcode == `SXE_OP_SWAP);
    wire is_xch = (hi == `SXE_GRP_XCH) && (lo > `SXE_LO_IMM);
    wire is_digit_exchange = (opcode == `SXE_OP_XCHD0) || (opcode == `SXE_OP_XCHD1);
    assign decode_hit = is_sub || is_xor || is_swap || is_xch || is_digit_exchange;
    assign busy = (state_reg != `SXE_ST_IDLE);

    wire in_ind = (lo == `SXE_LO_IND0) || (lo == `SXE_LO_IND1);
    wire in_reg = opcode[3];
    wire in_imm = (lo == `SXE_LO_IMM) && !is_swap;
    wire in_dir = (lo == `SXE_LO_DIR) || (is_xor && (lo == `SXE_LO_XOR_DA))
                  || (is_xor && (lo == `SXE_LO_XOR_DI));

    // Length and documented cycle count reported to the fetch sequencer
    assign instr_bytes = !decode_hit ? 2'h0 :
                         (is_xor && lo == `SXE_LO_XOR_DI) ? `SXE_BYTES_3 :
                         (in_imm || in_dir) ? `SXE_BYTES_2 : `SXE_BYTES_1;
    assign instr_cycles = !decode_hit ? 2'h0 :
                          (is_xor && lo == `SXE_LO_XOR_DI) ? `SXE_CYC_2 :
                          `SXE_CYC_1;

    // Decode of the latched opcode for execution
    wire [3:0] hi_q = op_reg[7:4];
    wire [3:0] lo_q = op_reg[3:0];
    wire q_sub = (hi_q == `SXE_GRP_SUB);
    wire q_xor = (hi_q == `SXE_GRP_XOR);
    wire q_swap = (op_reg == `SXE_OP_SWAP);
    wire q_digit_exchange = (hi_q == `SXE_GRP_DIGIT_EXCHANGE);
    wire q_xch = (hi_q == `SXE_GRP_XCH) && !q_swap;
    wire q_imm = (lo_q == `SXE_LO_IMM);
    wire q_ind = (lo_q == `SXE_LO_IND0) || (lo_q == `SXE_LO_IND1);
    wire q_reg = op_reg[3];
    wire q_xor_da = q_xor && (lo_q == `SXE_LO_XOR_DA);
    wire q_xor_di = q_xor && (lo_q == `SXE_LO_XOR_DI);
    wire q_dest_dir = q_xor_da || q_xor_di;

    wire [DW-1:0] src = q_imm ? b1_reg : opnd_reg;

    // Borrow chain for subtraction
    wire [4:0] low_diff = {1'b0, acc_reg[3:0]} - {1'b0, src[3:0]} - {4'h0, cy_reg};
    wire [7:0] mid_diff = {1'b0, acc_reg[6:0]} - {1'b0, src[6:0]} - {7'h00, cy_reg};
    wire [8:0] full_diff = {1'b0, acc_reg} - {1'b0, src} - {8'h00, cy_reg};
    wire bor7 = full_diff[8];
    wire bor3 = low_diff[4];
    wire bor6 = mid_diff[7];

    wire [DW-1:0] xor_val = opnd_reg ^ (q_xor_di ? b2_reg : acc_reg);
    wire [7:0] reg_addr = {3'h0, bank_sel, op_reg[2:0]};
    wire [7:0] wr_addr = q_ind ? ptr_reg : (q_reg ? reg_addr : b1_reg);

    always @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= `SXE_ST_IDLE;
            op_reg <= 8'h00;
            b1_reg <= 8'h00;
            b2_reg <= 8'h00;
            acc_reg <= {DW{1'b0}};
            cy_reg <= 1'b0;
            ac_reg <= 1'b0;
            ov_reg <= 1'b0;
            ptr_reg <= 8'h00;
            opnd_reg <= {DW{1'b0}};
            mem_rd_req_reg <= 1'b0;
            mem_rd_addr_reg <= 8'h00;
            mem_rd_indirect_reg <= 1'b0;
            mem_rd_latch_reg <= 1'b0;
            mem_wr_en_reg <= 1'b0;
            mem_wr_addr_reg <= 8'h00;
            mem_wr_indirect_reg <= 1'b0;
            mem_wr_data_reg <= {DW{1'b0}};
            acc_wr_en_reg <= 1'b0;
            acc_wr_data_reg <= {DW{1'b0}};
            flag_wr_en_reg <= 1'b0;
            carry_out_reg <= 1'b0;
            auxiliary_carry_flag_out_reg <= 1'b0;
            overflow_flag_out_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            mem_wr_en_reg <= 1'b0;
            acc_wr_en_reg <= 1'b0;
            flag_wr_en_reg <= 1'b0;
            done_reg <= 1'b0;
            case (state_reg)
                `SXE_ST_IDLE: begin
                    mem_rd_req_reg <= 1'b0;
                    mem_rd_latch_reg <= 1'b0;
                    if (exec_start && decode_hit) begin
                        op_reg <= opcode;
                        b1_reg <= byte1;
                        b2_reg <= byte2;
                        acc_reg <= acc_in;
                        cy_reg <= carry_in;
                        ac_reg <= auxiliary_carry_flag_in;
                        ov_reg <= overflow_flag_in;
                        if (in_ind && !is_swap) begin
                            // Fetch pointer register of active bank
                            mem_rd_req_reg <= 1'b1;
                            mem_rd_addr_reg <= {3'h0, bank_sel, 2'h0, opcode[0]};
                            mem_rd_indirect_reg <= 1'b0;
                            state_reg <= `SXE_ST_PTR;
                        end else if (in_reg || in_dir) begin
                            mem_rd_req_reg <= 1'b1;
                            mem_rd_addr_reg <= in_reg ? {3'h0, bank_sel, opcode[2:0]} : byte1;
                            mem_rd_indirect_reg <= 1'b0;
                            mem_rd_latch_reg <= is_xor && !in_reg
                                                && (lo < `SXE_LO_IMM);
                            state_reg <= `SXE_ST_OPR;
                        end else begin
                            state_reg <= `SXE_ST_EXEC;
                        end
                    end
                end
                `SXE_ST_PTR: begin
                    ptr_reg <= mem_rd_data[7:0];
                    mem_rd_addr_reg <= mem_rd_data[7:0];
                    mem_rd_indirect_reg <= 1'b1;
                    state_reg <= `SXE_ST_OPR;
                end
                `SXE_ST_OPR: begin
                    opnd_reg <= mem_rd_data;
                    mem_rd_req_reg <= 1'b0;
                    mem_rd_latch_reg <= 1'b0;
                    state_reg <= `SXE_ST_EXEC;
                end
                `SXE_ST_EXEC: begin
                    done_reg <= 1'b1;
                    mem_wr_addr_reg <= wr_addr;
                    mem_wr_indirect_reg <= q_ind;
                    // Unchanged flags shown; subtract overrides below
                    carry_out_reg <= cy_reg;
                    auxiliary_carry_flag_out_reg <= ac_reg;
                    overflow_flag_out_reg <= ov_reg;
                    if (q_sub) begin
                        acc_wr_en_reg <= 1'b1;
                        acc_wr_data_reg <= full_diff[7:0];
                        flag_wr_en_reg <= 1'b1;
                        carry_out_reg <= bor7;
                        auxiliary_carry_flag_out_reg <= bor3;
                        overflow_flag_out_reg <= bor6 ^ bor7;
                    end else if (q_swap) begin
                        acc_wr_en_reg <= 1'b1;
                        acc_wr_data_reg <= {acc_reg[3:0], acc_reg[7:4]};
                    end else if (q_xch) begin
                        acc_wr_en_reg <= 1'b1;
                        acc_wr_data_reg <= opnd_reg;
                        mem_wr_en_reg <= 1'b1;
                        mem_wr_data_reg <= acc_reg;
                    end else if (q_digit_exchange) begin
                        acc_wr_en_reg <= 1'b1;
                        acc_wr_data_reg <= {acc_reg[7:4], opnd_reg[3:0]};
                        mem_wr_en_reg <= 1'b1;
                        mem_wr_data_reg <= {opnd_reg[7:4], acc_reg[3:0]};
                    end else if (q_dest_dir) begin
                        mem_wr_en_reg <= 1'b1;
                        mem_wr_data_reg <= xor_val;
                    end else begin
                        acc_wr_en_reg <= 1'b1;
                        acc_wr_data_reg <= acc_reg ^ src;
                    end
                    state_reg <= `SXE_ST_IDLE;
                end
                default: begin
                    state_reg <= `SXE_ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ==== sxe_consts.vh ====
// Constants for the subtract, swap, exchange and exclusive-OR executor
`ifndef SXE_CONSTS_VH
`define SXE_CONSTS_VH

`define SXE_GRP_SUB 4'h9
`define SXE_GRP_XOR 4'h6
`define SXE_GRP_XCH 4'hc
`define SXE_GRP_DIGIT_EXCHANGE 4'hd
`define SXE_OP_SWAP 8'hc4
`define SXE_OP_XCHD0 8'hd6
`define SXE_OP_XCHD1 8'hd7

`define SXE_LO_XOR_DA 4'h2
`define SXE_LO_XOR_DI 4'h3
`define SXE_LO_IMM 4'h4
`define SXE_LO_DIR 4'h5
`define SXE_LO_IND0 4'h6
`define SXE_LO_IND1 4'h7

`define SXE_ST_IDLE 2'h0
`define SXE_ST_PTR 2'h1
`define SXE_ST_OPR 2'h2
`define SXE_ST_EXEC 2'h3

`define SXE_BYTES_1 2'h1
`define SXE_BYTES_2 2'h2
`define SXE_BYTES_3 2'h3
`define SXE_CYC_1 2'h1
`define SXE_CYC_2 2'h2

`endif

// ==== sxe_exec_assertions.sv ====
// Port checks for the executor
`timescale 1ns/1ps
module sxe_exec_assertions (
    input wire clock,
    input wire rst_n,
    input wire exec_start,
    input wire [7:0] opcode,
    input wire [7:0] acc_in,
    input wire [1:0] bank_sel,
    input wire decode_hit,
    input wire busy,
    input wire mem_rd_req_reg,
    input wire [7:0] mem_rd_addr_reg,
    input wire mem_rd_latch_reg,
    input wire mem_wr_en_reg,
    input wire [7:0] mem_wr_data_reg,
    input wire acc_wr_en_reg,
    input wire [7:0] acc_wr_data_reg,
    input wire flag_wr_en_reg,
    input wire done_reg
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire take = exec_start && !busy && decode_hit;
    reg [7:0] op_reg, a_reg;
    always @(posedge clock) if (take) begin
        op_reg <= opcode;
        a_reg <= acc_in;
    end
    AST_IMM: assert property (take && opcode[3:0] == 4'h4 |-> ##2 done_reg) else $error("imm");
    AST_REG: assert property (take && (opcode[3] || opcode[3:0] == 4'h5)
        |-> ##1 !done_reg ##1 !done_reg ##1 done_reg) else $error("reg latency");
    AST_IND: assert property (take && opcode[3:1] == 3'h3 |=> busy[*3] ##1 done_reg) else $error("ind");
    AST_PTR: assert property (take && opcode[3:1] == 3'h3 |=> mem_rd_req_reg
        && mem_rd_addr_reg == {3'h0, bank_sel, 2'h0, $past(opcode[0])}) else $error("ptr");
    AST_LATCH: assert property (take && opcode[7:1] == 7'h31 |=> mem_rd_latch_reg) else $error("latch");
    AST_FLAGS: assert property (done_reg |-> flag_wr_en_reg == (op_reg[7:4] == 4'h9)) else $error("flags");
    AST_SWAP: assert property (done_reg && op_reg == 8'hc4
        |-> acc_wr_data_reg == {a_reg[3:0], a_reg[7:4]}) else $error("swap");
    AST_XCH: assert property (done_reg && op_reg[7:5] == 3'h6 && op_reg != 8'hc4
        |-> mem_wr_en_reg && mem_wr_data_reg[3:0] == a_reg[3:0]) else $error("xch");
    C_SUB: cover property (take && opcode == 8'h94);
    C_IND: cover property (take && opcode[3:1] == 3'h3);
    C_XD: cover property (done_reg && op_reg == 8'h63);
endmodule

// ==== sxe_mem_model.sv ====
// Register bank and RAM model behind the executor
`timescale 1ns/1ps
module sxe_mem_model (
    input wire clock,
    input wire rd_req,
    input wire rd_ind,
    input wire [7:0] rd_addr,
    input wire wr_en,
    input wire wr_ind,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    output wire [7:0] rd_data
);
    reg [7:0] mem [0:511];
    reg [7:0] last_reg = 8'h00;
    // Idle bus shows inverse of last byte
    assign rd_data = rd_req ? mem[{rd_ind, rd_addr}] : ~last_reg;
    always @(posedge clock) begin
        if (rd_req) last_reg <= rd_data;
        if (wr_en) mem[{wr_ind, wr_addr}] <= wr_data;
    end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the executor
`timescale 1ns/1ps
module testbench;
    reg clock, rst_n, exec_start, cin;
    reg [7:0] opcode, byte1, byte2, acc_in;
    reg [1:0] bank, fl;
    wire [7:0] rdd, rda, wra, wrd, ad;
    wire [1:0] nb, nc;
    wire hit, busy, rq, ri, lt, we, wi, ae, fe, co, aco, ovo, done;
    reg [31:0] lf = 32'hb9d0;
    reg [30:0] q [$];
    reg [7:0] ops [0:19] = '{8'h94, 8'h98, 8'h95, 8'h96, 8'h97, 8'hc4, 8'hc8, 8'hc5, 8'hc6,
        8'hc7, 8'hd6, 8'hd7, 8'h68, 8'h65, 8'h66, 8'h67, 8'h64, 8'h62, 8'h63, 8'ha5};
    integer fail_count = 0, n_compared = 0, i;
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    sxe_exec i_dut (.clock(clock), .rst_n(rst_n), .exec_start(exec_start), .opcode(opcode),
        .byte1(byte1), .byte2(byte2), .acc_in(acc_in), .carry_in(cin),
        .auxiliary_carry_flag_in(fl[0]), .overflow_flag_in(fl[1]), .bank_sel(bank),
        .mem_rd_data(rdd), .decode_hit(hit), .busy(busy), .instr_bytes(nb), .instr_cycles(nc),
        .mem_rd_req_reg(rq), .mem_rd_addr_reg(rda), .mem_rd_indirect_reg(ri),
        .mem_rd_latch_reg(lt), .mem_wr_en_reg(we), .mem_wr_addr_reg(wra),
        .mem_wr_indirect_reg(wi), .mem_wr_data_reg(wrd), .acc_wr_en_reg(ae),
        .acc_wr_data_reg(ad), .flag_wr_en_reg(fe), .carry_out_reg(co),
        .auxiliary_carry_flag_out_reg(aco), .overflow_flag_out_reg(ovo), .done_reg(done));
    sxe_mem_model i_mem (.clock(clock), .rd_req(rq), .rd_ind(ri), .rd_addr(rda), .wr_en(we),
        .wr_ind(wi), .wr_addr(wra), .wr_data(wrd), .rd_data(rdd));
    function [31:0] nxt(input [31:0] x);
        nxt = {x[30:0], 1'b0} ^ (x[31] ? 32'h000000c5 : 32'h0);
    endfunction
    function [30:0] expect_of(input [7:0] op, b1, b2, a, input c, input [1:0] bk);
        reg [8:0] p, d;
        reg [7:0] s, h;
        reg [4:0] l;
        reg [21:0] r;
        begin
            p = op[3] ? {4'h0, bk, op[2:0]} : (op[3:1] == 3'h3)
                ? {1'b1, i_mem.mem[{4'h0, bk, 2'h0, op[0]}]} : {1'b0, b1};
            s = (op[3:0] == 4'h4) ? b1 : i_mem.mem[p];
            d = {1'b0, a} - s - c;
            l = {1'b0, a[3:0]} - s[3:0] - c;
            h = {1'b0, a[6:0]} - s[6:0] - c;
            case (op[7:4])
                4'h9: r = {1'b1, d[7:0], 9'h0, 1'b1, d[8], l[4], d[8] ^ h[7]};
                4'h6: r = (op[3:1] == 3'h1) ? {9'h0, 1'b1, s ^ (op[0] ? b2 : a), 4'h0}
                    : {1'b1, a ^ s, 13'h0};
                4'hc: r = (op == 8'hc4) ? {1'b1, a[3:0], a[7:4], 13'h0}
                    : {1'b1, s, 1'b1, a, 4'h0};
                default: r = {1'b1, a[7:4], s[3:0], 1'b1, s[7:4], a[3:0], 4'h0};
            endcase
            // Any write lands back at the operand location
            expect_of = {r, r[12] ? p : 9'h0};
        end
    endfunction
    task bad(input [8*12-1:0] m);
        begin
            $display("BAD %0t %0s", $time, m);
            fail_count++;
        end
    endtask
    task go(input [7:0] op0);
        reg [7:0] op;
        reg [3:0] bc;
        integer k;
        begin
            lf = nxt(nxt(nxt(lf)));
            op = op0[3] ? {op0[7:3], lf[2:0]} : op0;
            bc = (op == 8'h63) ? 4'he : (op == 8'ha5) ? 4'h0
                : (op[3:0] inside {4'h2, 4'h4, 4'h5} && op != 8'hc4) ? 4'h9 : 4'h5;
            @(posedge clock);
            opcode <= op;
            byte1 <= lf[15:8];
            byte2 <= lf[23:16];
            acc_in <= lf[31:24];
            {fl, cin, bank} <= lf[7:3];
            exec_start <= 1'b1;
            // Model read only after the previous write has landed
            @(negedge clock);
            if (op != 8'ha5)
                q.push_back(expect_of(op, lf[15:8], lf[23:16], lf[31:24], lf[5], lf[4:3]));
            n_compared++;
            if ({nb, nc} !== bc) bad("length code");
            @(posedge clock);
            opcode <= 8'ha5;
            @(posedge clock);
            exec_start <= 1'b0;
            for (k = 0; done !== 1'b1 && k < 8; k++) @(negedge clock);
            if (k == 8 && op != 8'ha5) bad("no done");
        end
    endtask
    always @(negedge clock) if (done === 1'b1) begin
        n_compared++;
        if (q.size() == 0 || {ae, ae ? ad : 8'h00, we, we ? wrd : 8'h00, fe,
            fe ? {co, aco, ovo} : 3'h0, we ? {wi, wra} : 9'h0} !== q.pop_front())
            bad("result");
    end
    task report_and_stop;
        begin
            $display("compared %0d mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        {rst_n, exec_start, cin, fl, bank} = 0;
        {opcode, byte1, byte2, acc_in} = 0;
        for (i = 0; i < 512; i++) begin
            lf = nxt(lf);
            i_mem.mem[i] = lf[7:0];
        end
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        for (i = 0; i < 60; i++) go(ops[i % 20]);
        repeat (4) @(posedge clock);
        if (q.size() != 0) bad("missing");
        report_and_stop;
    end
    initial begin
        repeat (3000) @(posedge clock);
        bad("watchdog");
        report_and_stop;
    end
endmodule
bind sxe_exec sxe_exec_assertions i_chk (.clock(clock), .rst_n(rst_n), .exec_start(exec_start),
    .opcode(opcode), .acc_in(acc_in), .bank_sel(bank_sel), .decode_hit(decode_hit), .busy(busy),
    .mem_rd_req_reg(mem_rd_req_reg), .mem_rd_addr_reg(mem_rd_addr_reg),
    .mem_rd_latch_reg(mem_rd_latch_reg), .mem_wr_en_reg(mem_wr_en_reg),
    .mem_wr_data_reg(mem_wr_data_reg), .acc_wr_en_reg(acc_wr_en_reg),
    .acc_wr_data_reg(acc_wr_data_reg), .flag_wr_en_reg(flag_wr_en_reg), .done_reg(done_reg));
